// file: design/vsl_pkg.sv
package vsl_pkg;

    // register subaddresses on the serial control bus
    localparam logic [7:0] SYNC_CTRL_ADDR = 8'h08;
    localparam logic [7:0] LUMA_CTRL_ADDR = 8'h09;

    // reset values, chosen to match the usual operating setup
    localparam logic [7:0] SYNC_CTRL_RESET = 8'hD8;
    localparam logic [7:0] LUMA_CTRL_RESET = 8'h40;

    // sync control field positions
    localparam int AUTO_FIELD_BIT = 7;
    localparam int RATE_SEL_BIT = 6;
    localparam int FORCE_TOGGLE_BIT = 5;
    localparam int TCONST_LSB = 3;
    localparam int LOOP_OPEN_BIT = 2;
    localparam int NOISE_MODE_LSB = 0;

    // luma control field positions
    localparam int BYPASS_BIT = 7;
    localparam int COMB_BIT = 6;
    localparam int EXTRA_DELAY_BIT = 5;
    localparam int REMOD_BW_BIT = 4;
    localparam int SHARP_LSB = 0;

    // extra line delay in lines per standard
    localparam logic [1:0] EXTRA_LINES_NTSC = 2'h1;
    localparam logic [1:0] EXTRA_LINES_PAL = 2'h2;

    // sharpness codes
    localparam logic [3:0] SHARP_PLAIN = 4'h0;
    localparam logic [3:0] SHARP_NOTCH_FIRST = 4'hD;

    typedef enum logic [1:0]
    {
        VSL_TC_TV = 2'b00,
        VSL_TC_VTR = 2'b01,
        VSL_TC_RSVD = 2'b10,
        VSL_TC_FAST = 2'b11
    } vsl_tconst_t;

    typedef enum logic [1:0]
    {
        VSL_VNR_NORMAL = 2'b00,
        VSL_VNR_FAST = 2'b01,
        VSL_VNR_FREE = 2'b10,
        VSL_VNR_BYPASS = 2'b11
    } vsl_vnr_t;

    typedef enum logic [1:0]
    {
        VSL_LF_TRAP = 2'b00,
        VSL_LF_COMB = 2'b01,
        VSL_LF_BYPASS = 2'b10
    } vsl_lfilt_t;

    // decoded controls delivered to the video path
    typedef struct packed
    {
        logic field_60hz;
        logic field_auto;
        logic toggle_forced;
        vsl_tconst_t tconst;
        logic tconst_reserved;
        logic hloop_open;
        vsl_vnr_t vnr;
        vsl_lfilt_t luma_filter;
        logic [1:0] extra_lines;
        logic wide_notch;
        logic sharp_plain;
        logic sharp_enhance;
        logic sharp_lowpass;
        logic [2:0] sharp_step;
        logic [1:0] notch_sel;
    } vsl_ctrl_t;

    typedef struct packed
    {
        logic [7:0] sync_ctrl;
        logic [7:0] luma_ctrl;
        logic [7:0] rdata;
        logic odd_even;
        vsl_ctrl_t ctrl;
    } vsl_state_t;

endpackage : vsl_pkg

// file: design/vsl_regs.sv
// Behaviour
// - auto field detect set: device picks field rate; cleared: manual select rules
// - manual select used only when auto is off; 0 is 50 Hz/625, 1 is 60 Hz/525
// - toggle bit clear: odd/even toggles for interlaced only; set: every field
// - time constant: 00 TV, 01 VTR, 11 fast lock, 10 reserved
// - loop open bit 0 closes the horizontal loop; 1 holds frequency fixed
// - noise mode: 00 normal, 01 fast, 10 free running, 11 bypass
// - bypass bit 0 keeps trap or comb active; 1 bypasses filtering
// - with bypass clear, comb bit 1 uses adaptive comb, 0 uses trap
// - extra delay bit adds one line for NTSC, two for PAL
// - bandwidth bit 0 narrow notch, 1 wider notch
// - sharpness 0000 plain; 0001..0111 enhancement boost falling 8.0 to 1.6 dB
// - sharpness 1000..1111 narrower low-pass; top three codes add notches
`timescale 1ns/1ps
`default_nettype none

module vsl_regs
(
    // clock, reset, enable
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic CLK_EN,
    // register port from the serial bus controller
    input wire logic [7:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_RD,
    output logic [7:0] REG_RDATA,
    // video status from the decoder core
    input wire logic DET_60HZ,
    input wire logic SRC_INTERLACED,
    input wire logic FIELD_START,
    // decoded controls and field flag
    output vsl_pkg::vsl_ctrl_t CTRL,
    output logic ODD_EVEN
);

    vsl_pkg::vsl_state_t st;
    vsl_pkg::vsl_state_t next_st;

    always_comb
    begin
        logic [7:0] s;
        logic [7:0] l;
        logic [3:0] sharp;
        s = st.sync_ctrl;
        l = st.luma_ctrl;
        sharp = l[vsl_pkg::SHARP_LSB +: 4];
        next_st = st;
        if (REG_WR && REG_ADDR == vsl_pkg::SYNC_CTRL_ADDR)
        begin
            next_st.sync_ctrl = REG_WDATA;
        end
        if (REG_WR && REG_ADDR == vsl_pkg::LUMA_CTRL_ADDR)
        begin
            next_st.luma_ctrl = REG_WDATA;
        end
        // unmapped subaddresses read back as zero
        if (REG_RD)
        begin
            case (REG_ADDR)
                vsl_pkg::SYNC_CTRL_ADDR: next_st.rdata = st.sync_ctrl;
                vsl_pkg::LUMA_CTRL_ADDR: next_st.rdata = st.luma_ctrl;
                default: next_st.rdata = 8'h00;
            endcase
        end
        // controls decode from the stored value, so a write lands one clock later
        next_st.ctrl.field_auto = s[vsl_pkg::AUTO_FIELD_BIT];
        if (s[vsl_pkg::AUTO_FIELD_BIT])
        begin
            next_st.ctrl.field_60hz = DET_60HZ;
        end
        else
        begin
            next_st.ctrl.field_60hz = s[vsl_pkg::RATE_SEL_BIT];
        end
        next_st.ctrl.toggle_forced = s[vsl_pkg::FORCE_TOGGLE_BIT];
        next_st.ctrl.tconst = vsl_pkg::vsl_tconst_t'(s[vsl_pkg::TCONST_LSB +: 2]);
        // reserved code passed through but flagged; the core may treat it as it likes
        case (s[vsl_pkg::TCONST_LSB +: 2])
            2'h2:
            begin
                next_st.ctrl.tconst_reserved = 1'b1;
            end
            default:
            begin
                next_st.ctrl.tconst_reserved = 1'b0;
            end
        endcase
        next_st.ctrl.hloop_open = s[vsl_pkg::LOOP_OPEN_BIT];
        next_st.ctrl.vnr = vsl_pkg::vsl_vnr_t'(s[vsl_pkg::NOISE_MODE_LSB +: 2]);
        if (l[vsl_pkg::BYPASS_BIT])
        begin
            next_st.ctrl.luma_filter = vsl_pkg::VSL_LF_BYPASS;
        end
        else if (l[vsl_pkg::COMB_BIT])
        begin
            next_st.ctrl.luma_filter = vsl_pkg::VSL_LF_COMB;
        end
        else
        begin
            next_st.ctrl.luma_filter = vsl_pkg::VSL_LF_TRAP;
        end
        if (!l[vsl_pkg::EXTRA_DELAY_BIT])
        begin
            next_st.ctrl.extra_lines = 2'h0;
        end
        else
        begin
            next_st.ctrl.extra_lines = next_st.ctrl.field_60hz ? vsl_pkg::EXTRA_LINES_NTSC
                                                               : vsl_pkg::EXTRA_LINES_PAL;
        end
        next_st.ctrl.wide_notch = l[vsl_pkg::REMOD_BW_BIT];
        next_st.ctrl.sharp_plain = (sharp == vsl_pkg::SHARP_PLAIN);
        next_st.ctrl.sharp_enhance = !sharp[3] && (sharp[2:0] != 3'h0);
        next_st.ctrl.sharp_lowpass = sharp[3];
        next_st.ctrl.sharp_step = sharp[2:0];
        // notch select: 0 none, 1 at 3.4, 2 at 3.0, 3 at 2.5 MHz
        if (sharp >= vsl_pkg::SHARP_NOTCH_FIRST)
        begin
            next_st.ctrl.notch_sel = 2'(sharp - vsl_pkg::SHARP_NOTCH_FIRST + 4'h1);
        end
        else
        begin
            next_st.ctrl.notch_sel = 2'h0;
        end
        if (FIELD_START && (SRC_INTERLACED || s[vsl_pkg::FORCE_TOGGLE_BIT]))
        begin
            next_st.odd_even = !st.odd_even;
        end
    end

    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            st <= '0;
            st.sync_ctrl <= vsl_pkg::SYNC_CTRL_RESET;
            st.luma_ctrl <= vsl_pkg::LUMA_CTRL_RESET;
        end
        else if (CLK_EN)
        begin
            st <= next_st;
        end
    end

    assign REG_RDATA = st.rdata;
    assign CTRL = st.ctrl;
    assign ODD_EVEN = st.odd_even;

endmodule : vsl_regs

`default_nettype wire

// file: tb/vsl_host.sv
`timescale 1ns/1ps
`default_nettype none
module vsl_host
(
    // clock and read data
    input wire logic CLK,
    input wire logic [7:0] REG_RDATA,
    // requests
    output logic [7:0] REG_ADDR,
    output logic REG_WR,
    output logic REG_RD,
    output logic [7:0] REG_WDATA
);
    // reset values already give the customary composite setup
    initial {REG_ADDR, REG_WR, REG_RD, REG_WDATA} = 18'h0;
    task automatic wr(input logic [7:0] a, inout logic [7:0] d);
        if (a == 8'h08 && d[1:0] == 2'h1)
            d[7] = 1'b0; // fast noise mode only with auto detect off
        {REG_ADDR, REG_WDATA, REG_WR} = {a, d, 1'b1};
        @(posedge CLK) #1;
        // stale data on the bus would hide a late sample
        {REG_WDATA, REG_WR} = {~d, 1'b0};
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        {REG_ADDR, REG_RD} = {a, 1'b1};
        @(posedge CLK) #1;
        REG_RD = 1'b0;
        q = REG_RDATA;
    endtask : rd
endmodule : vsl_host
`default_nettype wire

// file: tb/vsl_regs_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module vsl_regs_monitor
(
    // clock and reset
    input wire logic CLK,
    input wire logic SYS_RST,
    // watched ports
    input wire logic CLK_EN,
    input wire logic [7:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_RD,
    input wire logic [7:0] REG_RDATA,
    input wire logic DET_60HZ,
    input wire logic SRC_INTERLACED,
    input wire logic FIELD_START,
    input wire vsl_pkg::vsl_ctrl_t CTRL,
    input wire logic ODD_EVEN
);
    default clocking mcb @(posedge CLK);
    endclocking
    default disable iff (SYS_RST);
    // a quiet edge follows so a second write cannot mask the decode
    sequence taken_wr(logic [7:0] a);
        CLK_EN && REG_WR && REG_ADDR == a ##1 CLK_EN && !REG_WR;
    endsequence
    auto_field_a: assert property (taken_wr(8'h08) |=> CTRL.field_auto == $past(REG_WDATA[7], 2))
        else $error("auto field flag wrong");
    manual_rate_a: assert property (taken_wr(8'h08) |=> $past(REG_WDATA[7], 2) || CTRL.field_60hz == $past(REG_WDATA[6], 2))
        else $error("manual rate wrong");
    time_const_a: assert property (taken_wr(8'h08) |=> CTRL.tconst == $past(REG_WDATA[4:3], 2))
        else $error("time constant wrong");
    luma_bypass_a: assert property (taken_wr(8'h09) |=> CTRL.luma_filter[1] == $past(REG_WDATA[7], 2))
        else $error("bypass wrong");
    field_toggle_a: assert property (CLK_EN && FIELD_START && SRC_INTERLACED |=> ODD_EVEN != $past(ODD_EVEN))
        else $error("no toggle");
    field_hold_a: assert property (!(CLK_EN && FIELD_START) |=> $stable(ODD_EVEN))
        else $error("stray toggle");
    unmapped_read_a: assert property (CLK_EN && REG_RD && REG_ADDR[7:1] != 7'h04 |=> REG_RDATA == 8'h00)
        else $error("unmapped read");
    freeze_hold_a: assert property (!CLK_EN |=> $stable(CTRL) && $stable(REG_RDATA) && $stable(ODD_EVEN))
        else $error("moved while frozen");
    cover property (taken_wr(8'h08));
    cover property (taken_wr(8'h09));
    cover property (CLK_EN && FIELD_START && !SRC_INTERLACED);
endmodule : vsl_regs_monitor
`default_nettype wire

// file: tb/vsl_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module vsl_regs_tb_top;
    logic CLK = 1'b0;
    logic SYS_RST = 1'b1;
    logic CLK_EN = 1'b1;
    logic DET_60HZ = 1'b0;
    logic SRC_INTERLACED = 1'b0;
    logic FIELD_START = 1'b0;
    logic REG_WR, REG_RD, ODD_EVEN;
    logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA;
    vsl_pkg::vsl_ctrl_t CTRL;
    int fails = 0;
    int check_count = 0;
    int cyc = 0;
    vsl_regs dut (.CLK, .SYS_RST, .CLK_EN, .REG_ADDR, .REG_WR, .REG_WDATA, .REG_RD,
        .REG_RDATA, .DET_60HZ, .SRC_INTERLACED, .FIELD_START, .CTRL, .ODD_EVEN);
    vsl_host h (.CLK, .REG_RDATA, .REG_ADDR, .REG_WR, .REG_RD, .REG_WDATA);
    always #20 CLK = ~CLK;
    task automatic conclude;
        $display("checks %0d fails %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : conclude
    task automatic chk(input logic ok, input string m);
        check_count++;
        if (ok !== 1'b1)
        begin
            fails++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask : chk
    function automatic vsl_pkg::vsl_ctrl_t exp_ctrl(input logic [7:0] s, l, input logic det);
        logic f;
        f = s[7] ? det : s[6];
        return {f, s[7], s[5], s[4:3], s[4:3] == 2'b10, s[2], s[1:0],
            l[7] ? 2'b10 : {1'b0, l[6]}, l[5] ? (f ? 2'h1 : 2'h2) : 2'h0, l[4],
            l[3:0] == 4'h0, !l[3] && l[2:0] != 3'h0, l[3], l[2:0],
            l[3:0] > 4'hC ? l[1:0] : 2'h0};
    endfunction : exp_ctrl
    always @(posedge CLK)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            fails++;
            conclude();
        end
    end
    initial
    begin
        logic [7:0] a, d, q, sy, lu;
        logic oe;
        oe = 1'b0;
        sy = vsl_pkg::SYNC_CTRL_RESET;
        lu = vsl_pkg::LUMA_CTRL_RESET;
        void'($urandom(32'h9EF1CDE6));
        repeat (3) @(posedge CLK);
        #1 SYS_RST = 1'b0;
        h.rd(8'h08, q);
        chk(q === sy, "sync reset");
        h.rd(8'h09, q);
        chk(q === lu, "luma reset");
        repeat (80)
        begin
            a = 8'h08 + 8'($urandom % 3);
            d = 8'($urandom);
            DET_60HZ = 1'($urandom);
            h.wr(a, d);
            if (a == 8'h08)
                sy = d;
            if (a == 8'h09)
                lu = d;
            h.rd(a, q);
            chk(q === (a == 8'h08 ? sy : a == 8'h09 ? lu : 8'h00), "readback");
            chk(CTRL === exp_ctrl(sy, lu, DET_60HZ), "decode");
            SRC_INTERLACED = 1'($urandom);
            FIELD_START = 1'b1;
            oe = oe ^ (SRC_INTERLACED | sy[5]);
            @(posedge CLK) #1 FIELD_START = 1'b0;
            chk(ODD_EVEN === oe, "field flag");
        end
        CLK_EN = 1'b0;
        d = ~lu;
        h.wr(8'h09, d);
        CLK_EN = 1'b1;
        h.rd(8'h09, q);
        chk(q === lu, "frozen write");
        conclude();
    end
endmodule : vsl_regs_tb_top
bind vsl_regs vsl_regs_monitor mon (.CLK, .SYS_RST, .CLK_EN, .REG_ADDR, .REG_WR, .REG_WDATA,
    .REG_RD, .REG_RDATA, .DET_60HZ, .SRC_INTERLACED, .FIELD_START, .CTRL, .ODD_EVEN);
`default_nettype wire
